// ===== hdl/tll_map.vh
// Purpose: Constants for the three-wire latch loader host
// Assumes: 125 MHz system clock
// Notes:   Serial clock made by a divider from clk
`ifndef TLL_MAP_VH
`define TLL_MAP_VH
`define TLL_WORD_BITS       24
`define TLL_BYTE_BITS       8
`define TLL_SEL_CONTROL     2'b00
`define TLL_SEL_FEEDBACK    2'b10
`define TLL_SEL_REFERENCE   2'b01
`define TLL_CLK_MHZ         125
`define TLL_SCLK_MAX_MHZ    20
// Half period in clk cycles, rounded up so the serial clock stays at or under its limit
`define TLL_HALF_CYC        ((`TLL_CLK_MHZ + 2*`TLL_SCLK_MAX_MHZ - 1) / (2*`TLL_SCLK_MAX_MHZ))
`define TLL_DIV_W           4
`define TLL_CNT_W           5
`endif

// ===== hdl/tll_host.v
// Purpose: Host-side serial master that loads 24-bit words into a synthesizer's latches
// Assumes: Single clk domain; status pin is asynchronous and is synchronised here
// Notes:   Power-up runs the three-word init sequence before accepting user words
`timescale 1ns/1ps
`include "tll_map.vh"

// Operation
// - After power-up send reference, then control, then feedback counter words, exactly three.
// - Serial clock never runs faster than 20 MHz.
// - Strobe driven low before shifting and held low during the bits.
// - Word may go as three bytes; strobe rises after the third byte.
// - Data changes on falling edge so it is valid at the rising edge.
// - Host drives the power-gate input from a general output.
// - Host polls status output configured as lock detect.
// - Reference divider keeps comparison rate at or under 8 MHz.
// - Band-select clock divider enabled when reference output is fast.
// - DSP hosts may keep three 8-bit locations per word.
module tll_host (
    input  wire        clk,
    input  wire        reset_n,
    input  wire [23:0] init_ref_word,
    input  wire [23:0] init_ctl_word,
    input  wire [23:0] init_fb_word,
    input  wire        wr_valid,
    input  wire [23:0] wr_word,
    input  wire        power_enable,
    input  wire        multiplexed_status_output,
    output reg         wr_ready,
    output reg         init_done,
    output reg         lock_status,
    output reg         ser_clk,
    output reg         ser_data,
    output reg         latch_load_strobe,
    output reg         power_gate
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_LOW   = 3'd1;
    localparam ST_HIGH  = 3'd2;
    localparam ST_END   = 3'd3;
    localparam ST_LOAD  = 3'd4;

    // Counts kept as integers, then cut to the counter widths on purpose
    localparam integer          DIV_LAST_I = `TLL_HALF_CYC - 1;
    localparam integer          BIT_LAST_I = `TLL_WORD_BITS - 1;
    localparam [`TLL_DIV_W-1:0] DIV_LAST   = DIV_LAST_I[`TLL_DIV_W-1:0];
    localparam [`TLL_CNT_W-1:0] BIT_LAST   = BIT_LAST_I[`TLL_CNT_W-1:0];

    reg  [2:0]                state_q;
    reg  [2:0]                state_d;
    reg  [`TLL_DIV_W-1:0]     div_q;
    reg  [`TLL_DIV_W-1:0]     div_d;
    reg  [`TLL_CNT_W-1:0]     bit_q;
    reg  [`TLL_CNT_W-1:0]     bit_d;
    reg  [23:0]               shift_q;
    reg  [23:0]               shift_d;
    reg  [1:0]                init_idx_q;
    reg  [1:0]                init_idx_d;
    reg                       sync1_q;
    reg                       sync2_q;
    reg                       init_done_d;
    reg                       wr_ready_d;
    reg                       ser_clk_d;
    reg                       ser_data_d;
    reg                       strobe_d;
    reg  [23:0]               init_sel;
    wire                      tick;
    wire                      start_init;
    wire                      start_user;
    wire                      word_start;
    wire                      last_bit;
    wire [23:0]               next_word;

    // Every serial edge waits for this half-period tick, which keeps the link under its rate limit
    assign tick       = (div_q == DIV_LAST);
    assign start_init = (state_q == ST_IDLE) && !init_done;
    assign start_user = (state_q == ST_IDLE) && init_done && wr_valid && wr_ready;
    assign word_start = start_init || start_user;
    // Three bytes form one word; no strobe between bytes
    assign last_bit   = (bit_q == BIT_LAST);
    assign next_word  = start_init ? init_sel : wr_word;

    // Reference word content sets comparison rate and band-select divider; caller's duty
    always @* begin
        case (init_idx_q)
            2'd0:    init_sel = init_ref_word;
            2'd1:    init_sel = init_ctl_word;
            default: init_sel = init_fb_word;
        endcase
    end

    // Lock pin is asynchronous to clk
    always @(posedge clk) begin
        if (!reset_n) begin
            sync1_q     <= 1'b0;
            sync2_q     <= 1'b0;
            lock_status <= 1'b0;
            power_gate  <= 1'b0;
        end else begin
            sync1_q     <= multiplexed_status_output;
            sync2_q     <= sync1_q;
            lock_status <= sync2_q;
            power_gate  <= power_enable;
        end
    end

    // Divider, bit counter, shift register and init index
    always @* begin
        div_d      = tick ? {`TLL_DIV_W{1'b0}} : div_q + 1'b1;
        bit_d      = bit_q;
        shift_d    = shift_q;
        init_idx_d = init_idx_q;
        if (word_start) begin
            div_d   = {`TLL_DIV_W{1'b0}};
            bit_d   = {`TLL_CNT_W{1'b0}};
            // Words may go while power is gated: serial port stays alive
            shift_d = next_word;
        end else if ((state_q == ST_LOW) && tick) begin
            shift_d = {shift_q[22:0], 1'b0};
        end else if ((state_q == ST_HIGH) && tick) begin
            bit_d   = bit_q + 1'b1;
        end else if ((state_q == ST_LOAD) && tick && !init_done) begin
            init_idx_d = init_idx_q + 1'b1;
        end
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (word_start) begin
                    state_d = ST_LOW;
                end
            end
            ST_LOW: begin
                if (tick) begin
                    state_d = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (tick) begin
                    state_d = last_bit ? ST_END : ST_LOW;
                end
            end
            ST_END: begin
                if (tick) begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (tick) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Pin and handshake outputs; strobe stays high until the next word starts
    always @* begin
        init_done_d = init_done;
        wr_ready_d  = wr_ready;
        ser_clk_d   = ser_clk;
        ser_data_d  = ser_data;
        strobe_d    = latch_load_strobe;
        case (state_q)
            ST_IDLE: begin
                ser_clk_d = 1'b0;
                if (word_start) begin
                    strobe_d   = 1'b0;
                    wr_ready_d = 1'b0;
                end else begin
                    wr_ready_d = 1'b1;
                end
            end
            ST_LOW: begin
                if (tick) begin
                    // Data set up while clock is low so rising edge samples it
                    ser_clk_d  = 1'b0;
                    ser_data_d = shift_q[23];
                end
            end
            ST_HIGH: begin
                if (tick) begin
                    ser_clk_d = 1'b1;
                end
            end
            ST_END: begin
                if (tick) begin
                    ser_clk_d = 1'b0;
                end
            end
            ST_LOAD: begin
                if (tick) begin
                    strobe_d = 1'b1;
                    if (!init_done && (init_idx_q == 2'd2)) begin
                        init_done_d = 1'b1;
                    end
                end
            end
            default: begin
                ser_clk_d = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            state_q    <= ST_IDLE;
            div_q      <= {`TLL_DIV_W{1'b0}};
            bit_q      <= {`TLL_CNT_W{1'b0}};
            shift_q    <= 24'h000000;
            init_idx_q <= 2'd0;
        end else begin
            state_q    <= state_d;
            div_q      <= div_d;
            bit_q      <= bit_d;
            shift_q    <= shift_d;
            init_idx_q <= init_idx_d;
        end
    end

    // A reset in mid-word drops the word; init then runs again from the start
    always @(posedge clk) begin
        if (!reset_n) begin
            init_done         <= 1'b0;
            wr_ready          <= 1'b0;
            ser_clk           <= 1'b0;
            ser_data          <= 1'b0;
            latch_load_strobe <= 1'b0;
        end else begin
            init_done         <= init_done_d;
            wr_ready          <= wr_ready_d;
            ser_clk           <= ser_clk_d;
            ser_data          <= ser_data_d;
            latch_load_strobe <= strobe_d;
        end
    end
endmodule // tll_host

// ===== verification/tll_host_chk.sv
// Purpose: Port assertions for tll_host
// Assumes: One clk domain
// Notes:   Bound in the bench
`timescale 1ns/1ps
module tll_host_chk (
    input wire logic clk, reset_n, wr_valid, wr_ready, init_done, power_enable, multiplexed_status_output,
    input wire logic lock_status, ser_clk, ser_data, latch_load_strobe, power_gate);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_gate_follows: assert property ($past(reset_n) |-> power_gate == $past(power_enable)) else $error("gate");
    a_lock_delay: assert property ($rose(lock_status) |-> $past(multiplexed_status_output, 3)) else $error("lock");
    a_ready_init: assert property (wr_ready |-> init_done) else $error("ready");
    a_strobe_clk: assert property (latch_load_strobe |-> !ser_clk) else $error("strobe");
    a_shift_strobe_low: assert property ($rose(ser_clk) |-> !latch_load_strobe) else $error("shift strobe");
    a_take_drops: assert property (wr_valid && wr_ready |=> !wr_ready && !latch_load_strobe) else $error("take");
    a_data_hold: assert property (ser_clk |-> $stable(ser_data)) else $error("data");
    a_high_time: assert property ($rose(ser_clk) |-> ser_clk [*4] ##1 !ser_clk) else $error("high");
    a_word_time: assert property (wr_valid && wr_ready |-> ##[180:220] $rose(latch_load_strobe)) else $error("word");
endmodule // tll_host_chk

// ===== verification/tll_dev_model.sv
// Purpose: Behavioural synthesizer load port
// Assumes: Lock comes from the bench
// Notes:   Latched words only, no analog side
`timescale 1ns/1ps
module tll_dev_model (
    input wire logic ser_clk, ser_data, latch_load_strobe, power_gate, lock_in,
    output logic multiplexed_status_output,
    output logic [23:0] ref_q, ctl_q, fb_q,
    output logic [5:0] seq, bits);
    logic [23:0] sh_q = 24'h0;
    initial begin ref_q = 0; ctl_q = 0; fb_q = 0; seq = 0; bits = 0; end
    always @(negedge latch_load_strobe) bits = 0;
    // Shifts even while gated off
    always @(posedge ser_clk) begin sh_q = {sh_q[22:0], ser_data}; bits++; end
    always @(posedge latch_load_strobe) begin
        seq = {seq[3:0], sh_q[1:0]};
        case (sh_q[1:0]) 2'b00: ctl_q = sh_q; 2'b10: fb_q = sh_q; 2'b01: ref_q = sh_q; default: ; endcase
    end
    assign multiplexed_status_output = lock_in & power_gate;
endmodule // tll_dev_model

// ===== verification/tll_host_tb.sv
// Purpose: Self-checking bench for tll_host
// Assumes: Lock input of the model driven by the bench
// Notes:   Row 2 is sent with the device gated off
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin miscompares++; $display("BAD %s exp %h got %h", n, e, s); end end
module tll_host_tb;
    logic clk = 0, reset_n = 0, wr_valid = 0, power_enable = 1, lock_in = 1;
    logic [23:0] wr_word = 0;
    wire wr_ready, init_done, lock_status, ser_clk, ser_data, latch_load_strobe, power_gate, mso;
    wire [23:0] ref_q, ctl_q, fb_q;
    wire [5:0] seq, bits;
    int miscompares = 0, total_checks = 0, cyc = 0, w = 0;
    logic [25:0] rows[4] = '{26'h3fffffc, 26'h3000002, 26'h0a5a5a5, 26'h3123401}; // {power_enable, exp lock, word}
    // Reference word: divider keeps comparison rate low, band-select divider off
    tll_host dut_u (.clk(clk), .reset_n(reset_n), .init_ref_word(24'h00c801), .init_ctl_word(24'h4ff100),
        .init_fb_word(24'h000a02), .wr_valid(wr_valid), .wr_word(wr_word), .power_enable(power_enable),
        .multiplexed_status_output(mso), .wr_ready(wr_ready), .init_done(init_done), .lock_status(lock_status),
        .ser_clk(ser_clk), .ser_data(ser_data), .latch_load_strobe(latch_load_strobe), .power_gate(power_gate));
    tll_dev_model dev_u (.ser_clk(ser_clk), .ser_data(ser_data), .latch_load_strobe(latch_load_strobe),
        .power_gate(power_gate), .lock_in(lock_in), .multiplexed_status_output(mso), .ref_q(ref_q), .ctl_q(ctl_q),
        .fb_q(fb_q), .seq(seq), .bits(bits));
    always #4 clk = ~clk;
    always @(posedge clk) if (++cyc == 4000) begin miscompares++; end_of_test; end
    task end_of_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task send(input logic [25:0] r, output int n);
        @(posedge clk) #1 power_enable = r[25];
        for (int i = 0; i < 400 && wr_ready !== 1'b1; i++) @(posedge clk) #1;
        wr_valid = 1;
        wr_word = r[23:0];
        @(posedge clk) #1 wr_valid = 0;
        for (n = 0; n < 400 && latch_load_strobe !== 1'b1; n++) @(posedge clk) #1;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 reset_n = 1;
        for (int i = 0; i < 700 && init_done !== 1'b1; i++) @(posedge clk) #1;
        `CHK("init", 1'b1, init_done)
        `CHK("order", 6'b010010, seq)
        `CHK("fb", 24'h000a02, fb_q)
        foreach (rows[k]) begin
            send(rows[k], w);
            `CHK("cycles", 200, w)
            `CHK("bits", 6'd24, bits)
            `CHK("word", rows[k][23:0], rows[k][1:0] == 2'b00 ? ctl_q : rows[k][1:0] == 2'b10 ? fb_q : ref_q)
            `CHK("lock", rows[k][24], lock_status)
            @(posedge clk) #1;
            `CHK("ready", 1'b1, wr_ready)
            `CHK("gate", rows[k][25], power_gate)
            `CHK("sclk_idle", 1'b0, ser_clk)
        end
        // A request kept up while busy must be ignored
        wr_valid = 1;
        wr_word = 24'h0f0f01;
        @(posedge clk) #1 wr_word = 24'h5555fd;
        repeat (3) @(posedge clk) #1;
        `CHK("refuse", 1'b0, wr_ready)
        wr_valid = 0;
        for (w = 0; w < 400 && latch_load_strobe !== 1'b1; w++) @(posedge clk) #1;
        `CHK("kept", 24'h0f0f01, ref_q)
        lock_in = 0;
        repeat (5) @(posedge clk) #1;
        `CHK("unlock", 1'b0, lock_status)
        lock_in = 1;
        repeat (5) @(posedge clk) #1;
        `CHK("relock", 1'b1, lock_status)
        // Reset cuts a word; init must run again
        wr_valid = 1;
        wr_word = 24'h00aa02;
        @(posedge clk) #1 wr_valid = 0;
        repeat (50) @(posedge clk) #1;
        reset_n = 0;
        @(posedge clk) #1;
        `CHK("rst_clk", 1'b0, ser_clk)
        `CHK("rst_ready", 1'b0, wr_ready)
        `CHK("rst_init", 1'b0, init_done)
        `CHK("rst_gate", 1'b0, power_gate)
        reset_n = 1;
        for (w = 0; w < 700 && init_done !== 1'b1; w++) @(posedge clk) #1;
        `CHK("re_order", 6'b010010, seq)
        `CHK("re_ref", 24'h00c801, ref_q)
        `CHK("re_fb", 24'h000a02, fb_q)
        end_of_test;
    end
endmodule // tll_host_tb
bind tll_host tll_host_chk chk_u (.clk(clk), .reset_n(reset_n), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .init_done(init_done), .power_enable(power_enable), .multiplexed_status_output(multiplexed_status_output),
    .lock_status(lock_status), .ser_clk(ser_clk), .ser_data(ser_data), .latch_load_strobe(latch_load_strobe),
    .power_gate(power_gate));
